// >>> common/bfs_cfg.svh
// Offsets, field positions, reset values and timing counts of the sequencer.
// Assumes a single 125 MHz clock; included by bare name.
`ifndef BFS_CFG_SVH
`define BFS_CFG_SVH

// ****************************************
// Timing
// ****************************************
`define BFS_CLK_NS 8
`define BFS_OVP_FILT_NS 5000
`define BFS_OVP_CYC ((`BFS_OVP_FILT_NS + `BFS_CLK_NS - 1) / `BFS_CLK_NS)
`define BFS_OVP_W 10
`define BFS_UVP_CYC 8
`define BFS_UVP_W 4
`define BFS_SWO_CYC 32
`define BFS_SWO_W 6
`define BFS_ENL_WIN_CYC 2'h2

// ****************************************
// Comparator flag positions
// ****************************************
`define BFS_NFLAG 16
`define BFS_F_FB_B90 0
`define BFS_F_FB_A92 1
`define BFS_F_FB_A120 2
`define BFS_F_FB_B75 3
`define BFS_F_BIAS_3V0 4
`define BFS_F_BIAS_2V4 5
`define BFS_F_EN_LOW 6
`define BFS_F_EN_HIGH 7
`define BFS_F_ENL_2V6 8
`define BFS_F_ENL_2V4 9
`define BFS_F_ENL_1V 10
`define BFS_F_ENL_0V4 11
`define BFS_F_LDO_90 12
`define BFS_F_LDO_0V75 13
`define BFS_F_NEAR_300 14
`define BFS_F_HS_PULSE 15

// ****************************************
// Registers
// ****************************************
`define BFS_REG_CTRL 4'h0
`define BFS_REG_STAT 4'h4
`define BFS_REG_FAULT 4'h8
`define BFS_CTRL_RST 8'h03
`define BFS_CTRL_SWO_EN 0
`define BFS_CTRL_LDO_HOLD 1

`endif

// >>> common/bfs_pkg.sv
// Types shared by the sequencer files.
// Assumes bfs_cfg.svh is on the include path.
`include "bfs_cfg.svh"
package bfs_pkg;

    typedef logic [`BFS_NFLAG-1:0] bfs_flags_t;

    typedef enum logic [1:0] {
        BFS_SW_OFF,
        BFS_SW_RUN,
        BFS_SW_FAULT
    } bfs_sw_e;

    typedef enum logic [1:0] {
        BFS_ILIM_65,
        BFS_ILIM_115,
        BFS_ILIM_200
    } bfs_ilim_e;

    typedef struct packed {
        bfs_flags_t s1;
        bfs_flags_t s2;
        logic cyc_d;
        logic bias_ok;
        logic poc;
        bfs_sw_e st;
        logic fault_ov;
        logic fault_uv;
        logic pg_hyst;
        logic pg;
        logic enl_uv_ok;
        logic drop_win;
        logic [1:0] drop_cnt;
        logic fast_drop;
        logic ldo_on;
        logic sw_wait;
        logic swover;
        bfs_ilim_e ilim;
        logic [7:0] ctrl;
        logic [7:0] rdata;
        logic sw_on;
        logic ls_hold;
        logic tristate;
        logic light_load_save;
    } bfs_state_s;

    typedef struct packed {
        logic [9:0] cnt;
        logic hit;
    } bfs_pers_s;

endpackage

// >>> src/bfs_persist.sv
// Persistence counter: hit rises once cond has held for COUNT steps.
// Assumes cond and step are synchronous to clock_i.
`timescale 1ns/100ps
module bfs_persist
    import bfs_pkg::*;
#(
    parameter int WIDTH = 10,
    parameter int COUNT = 8
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic step_i,
    input wire logic cond_i,
    output logic hit_o
);

    bfs_pers_s r;
    bfs_pers_s next_r;
    logic [9:0] lim;

    assign lim = 10'(COUNT);

    // ****************************************
    // Count while the condition persists
    // ****************************************
    always_comb begin
        next_r = r;
        if (!cond_i) begin
            // Any gap restarts the count, so glitches never add up
            next_r.cnt = 10'h0;
        end else if (step_i && r.cnt != lim) begin
            next_r.cnt = r.cnt + 10'h1;
        end
        next_r.hit = cond_i && (next_r.cnt == lim);
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign hit_o = r.hit;

endmodule // bfs_persist

// >>> src/bfs_seq.sv
// Fault, power-good, enable decode and LDO sequencing of a buck regulator.
// Assumes comparator flags and the on-time pulse arrive on clock_i.
//
// Summary of operation
// - Power good drops under 90% feedback, returns above 92%.
// - Power good is low while feedback is over +20%.
// - Power good is low while bias is present and enable is low.
// - Over-voltage monitor is armed as soon as the switcher is enabled.
// - Over-voltage latches low-side on, controller off until enable or bias cycles.
// - Over-voltage must persist 5 us before tripping.
// - Power good stays low while the fault latch is set.
// - Feedback under 75% for eight cycles shuts off and tri-states drives.
// - Switching inhibited and drives tri-stated until bias exceeds 3.0 V.
// - Bias crossing 3.0 V clears fault latch and soft-start, then starts.
// - Switcher shuts off when bias falls below 2.4 V.
// - LDO enable low: LDO off; above threshold: LDO on, switcher qualified.
// - Fast LDO enable fall below 1 V: LDO off, switcher keeps running.
// - LDO enable between 1 V and threshold: switcher off, LDO keeps its state.
// - Input undervolt threshold uses 2.6 V rising, 2.4 V falling.
// - Switcher may run with LDO off when LDO enable is logic low, after a fast enable fall, or after switch-over.
// - LDO starts on enable and input ok; current limit staged 65/115/200.
// - Switch-over waits 32 cycles from power-good rise with LDO regulating.
// - Within 300 mV after the wait: close bias switch, disable LDO.
// - Enable pin: low off, float forced continuous, high power save.
`timescale 1ns/100ps
`include "bfs_cfg.svh"
module bfs_seq
    import bfs_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    input wire logic [`BFS_NFLAG-1:0] cmp_flags_i,
    output logic switcher_on_o,
    output logic low_side_drive_o,
    output logic drive_tristate_o,
    output logic light_load_save_o,
    output logic power_good_flag_o,
    output logic power_good_out_o,
    output logic power_good_oe_o,
    output logic ldo_on_o,
    output logic switchover_close_o,
    output logic soft_start_clear_o,
    output logic [1:0] ldo_ilim_o
);

    bfs_state_s r;
    bfs_state_s next_r;
    bfs_flags_t f;
    logic cyc;
    logic en_on;
    logic vin_ok;
    logic ldo_hold;
    logic run_ok;
    logic fault_clr;
    logic ovp_cond;
    logic uvp_cond;
    logic ovp_hit;
    logic uvp_hit;
    logic swo_hit;

    // ****************************************
    // Filters
    // ****************************************
    assign f = r.s2;
    assign cyc = f[`BFS_F_HS_PULSE] && !r.cyc_d;
    assign en_on = !f[`BFS_F_EN_LOW];
    // Armed on enable, no soft-start blanking
    assign ovp_cond = f[`BFS_F_FB_A120] && en_on && r.bias_ok;
    assign uvp_cond = f[`BFS_F_FB_B75] && (r.st == BFS_SW_RUN);

    bfs_persist #(.WIDTH(`BFS_OVP_W), .COUNT(`BFS_OVP_CYC)) u_ovp (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .step_i(1'b1),
        .cond_i(ovp_cond),
        .hit_o(ovp_hit)
    );

    bfs_persist #(.WIDTH(`BFS_UVP_W), .COUNT(`BFS_UVP_CYC)) u_uvp (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .step_i(cyc),
        .cond_i(uvp_cond),
        .hit_o(uvp_hit)
    );

    bfs_persist #(.WIDTH(`BFS_SWO_W), .COUNT(`BFS_SWO_CYC)) u_swo (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .step_i(cyc),
        .cond_i(r.sw_wait),
        .hit_o(swo_hit)
    );

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        next_r = r;
        next_r.s1 = cmp_flags_i;
        next_r.s2 = r.s1;
        next_r.cyc_d = f[`BFS_F_HS_PULSE];

        // Bias lockout with 3.0 V / 2.4 V hysteresis
        if (f[`BFS_F_BIAS_3V0]) begin
            next_r.bias_ok = 1'b1;
        end else if (!f[`BFS_F_BIAS_2V4]) begin
            next_r.bias_ok = 1'b0;
        end
        next_r.poc = next_r.bias_ok && !r.bias_ok;

        // Input undervolt on the LDO enable pin
        if (f[`BFS_F_ENL_2V6]) begin
            next_r.enl_uv_ok = 1'b1;
        end else if (!f[`BFS_F_ENL_2V4]) begin
            next_r.enl_uv_ok = 1'b0;
        end

        // Two-cycle window after the enable falls through its threshold
        if (r.enl_uv_ok && !next_r.enl_uv_ok) begin
            next_r.drop_win = 1'b1;
            next_r.drop_cnt = 2'h0;
        end else if (r.drop_win && cyc) begin
            next_r.drop_cnt = r.drop_cnt + 2'h1;
            if (next_r.drop_cnt == `BFS_ENL_WIN_CYC) begin
                next_r.drop_win = 1'b0;
            end
        end
        if (next_r.enl_uv_ok) begin
            next_r.fast_drop = 1'b0;
        end
        // Set wins over the clear
        if (r.drop_win && !f[`BFS_F_ENL_1V]) begin
            next_r.fast_drop = 1'b1;
        end

        // LDO enable; a slow fall above 1 V leaves it on
        if (r.swover) begin
            next_r.ldo_on = 1'b0;
        end else if (!f[`BFS_F_ENL_1V]) begin
            next_r.ldo_on = 1'b0;
        end else if (next_r.enl_uv_ok) begin
            next_r.ldo_on = 1'b1;
        end

        // Staged start-up current limit
        if (!next_r.ldo_on) begin
            next_r.ilim = BFS_ILIM_65;
        end else if (f[`BFS_F_LDO_90]) begin
            next_r.ilim = BFS_ILIM_200;
        end else if (f[`BFS_F_LDO_0V75]) begin
            next_r.ilim = BFS_ILIM_115;
        end else begin
            next_r.ilim = BFS_ILIM_65;
        end

        // Switcher qualification from the input side
        // Logic-low enable runs the switcher without input lockout
        vin_ok = next_r.enl_uv_ok || !f[`BFS_F_ENL_0V4] ||
            next_r.fast_drop;
        // Optional guard so switching cannot overload a starting LDO
        ldo_hold = r.ctrl[`BFS_CTRL_LDO_HOLD] && next_r.ldo_on &&
            !f[`BFS_F_LDO_90];
        run_ok = next_r.bias_ok && en_on && vin_ok && !ldo_hold;

        // Shared fault latch; a trip in the clearing cycle is kept
        fault_clr = !en_on || next_r.poc;
        next_r.fault_ov = (r.fault_ov && !fault_clr) || ovp_hit;
        next_r.fault_uv = (r.fault_uv && !fault_clr) ||
            (uvp_hit && r.st == BFS_SW_RUN);

        unique case (r.st)
            BFS_SW_OFF: begin
                if (run_ok && !next_r.fault_ov && !next_r.fault_uv) begin
                    next_r.st = BFS_SW_RUN;
                end
            end
            BFS_SW_RUN: begin
                if (next_r.fault_ov || next_r.fault_uv) begin
                    next_r.st = BFS_SW_FAULT;
                end else if (!run_ok) begin
                    next_r.st = BFS_SW_OFF;
                end
            end
            BFS_SW_FAULT: begin
                if (!next_r.fault_ov && !next_r.fault_uv) begin
                    next_r.st = BFS_SW_OFF;
                end
            end
            default: begin
                next_r.st = BFS_SW_OFF;
            end
        endcase
        if (next_r.poc) begin
            // Power-on clear restarts soft-start from the off state
            next_r.st = BFS_SW_OFF;
        end

        // Power good with 90 % / 92 % hysteresis
        if (f[`BFS_F_FB_B90]) begin
            next_r.pg_hyst = 1'b0;
        end else if (f[`BFS_F_FB_A92]) begin
            next_r.pg_hyst = 1'b1;
        end
        next_r.pg = (r.st == BFS_SW_RUN) && r.pg_hyst && en_on &&
            !f[`BFS_F_FB_A120] &&
            !next_r.fault_ov && !next_r.fault_uv;

        // Switch-over wait from the power-good rise
        if (next_r.pg && !r.pg && r.ldo_on && f[`BFS_F_LDO_90]) begin
            next_r.sw_wait = 1'b1;
        end else if (swo_hit || !next_r.pg) begin
            next_r.sw_wait = 1'b0;
        end
        if (next_r.st != BFS_SW_RUN) begin
            next_r.swover = 1'b0;
        end else if (swo_hit && r.sw_wait && f[`BFS_F_NEAR_300] &&
                r.ctrl[`BFS_CTRL_SWO_EN]) begin
            next_r.swover = 1'b1;
        end
        if (next_r.swover) begin
            next_r.ldo_on = 1'b0;
            next_r.ilim = BFS_ILIM_65;
        end

        // Gate drive states
        next_r.sw_on = next_r.st == BFS_SW_RUN;
        next_r.ls_hold = next_r.fault_ov;
        next_r.tristate = !next_r.sw_on && !next_r.fault_ov;
        next_r.light_load_save = next_r.sw_on && f[`BFS_F_EN_HIGH];

        // Register port; read data only in the cycle after the strobe
        if (reg_wr_i && reg_addr_i == `BFS_REG_CTRL) begin
            next_r.ctrl = reg_wdata_i;
        end
        next_r.rdata = 8'h00;
        if (reg_rd_i) begin
            unique case (reg_addr_i)
                `BFS_REG_CTRL: next_r.rdata = r.ctrl;
                `BFS_REG_STAT: next_r.rdata = {r.ilim, r.enl_uv_ok,
                    r.bias_ok, r.swover, r.ldo_on, r.pg, r.sw_on};
                `BFS_REG_FAULT: next_r.rdata = {5'h00, r.fast_drop,
                    r.fault_uv, r.fault_ov};
                default: next_r.rdata = 8'h00;
            endcase
        end
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            r <= '0;
            r.ctrl <= `BFS_CTRL_RST;
            r.tristate <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    assign reg_rdata_o = r.rdata;
    assign switcher_on_o = r.sw_on;
    assign low_side_drive_o = r.ls_hold;
    assign drive_tristate_o = r.tristate;
    assign light_load_save_o = r.light_load_save;
    assign power_good_flag_o = r.pg;
    // Open drain: pin only ever pulled low, released when good
    assign power_good_out_o = r.rdata[7] & 1'b0;
    assign power_good_oe_o = r.ls_hold | r.tristate | !r.pg;
    assign ldo_on_o = r.ldo_on;
    assign switchover_close_o = r.swover;
    assign soft_start_clear_o = r.poc;
    assign ldo_ilim_o = r.ilim;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!rst_n_i);

    AST_PG_UNDER: assert property (f[`BFS_F_FB_B90] |-> ##2 !r.pg)
        else $error("power good high under 90 percent");
    AST_PG_OVER: assert property (f[`BFS_F_FB_A120] |=> !r.pg)
        else $error("power good high above over-voltage level");
    AST_PG_EN: assert property (f[`BFS_F_EN_LOW] |=> !r.pg)
        else $error("power good high with enable low");
    AST_OV_HOLD: assert property (r.ls_hold && !f[`BFS_F_EN_LOW] &&
        !next_r.poc |=> r.ls_hold && !r.sw_on)
        else $error("over-voltage latch released early");
    AST_OV_FILT: assert property ($rose(r.fault_ov) |->
        $past(f[`BFS_F_FB_A120], 620))
        else $error("over-voltage tripped before filter time");
    AST_PG_FAULT: assert property (r.fault_ov || r.fault_uv |-> !r.pg)
        else $error("power good high with fault latched");
    AST_UV_TRI: assert property ($rose(r.fault_uv) && !r.fault_ov |->
        r.tristate && !r.sw_on)
        else $error("under-voltage did not tri-state drives");
    AST_BIAS_LOCK: assert property (!r.bias_ok |-> !r.sw_on && r.tristate
        || r.ls_hold)
        else $error("switching without bias");
    AST_POC: assert property (r.poc |-> !r.fault_ov && !r.fault_uv &&
        !r.sw_on)
        else $error("power-on clear left fault or switching");
    AST_BIAS_DROP: assert property (!f[`BFS_F_BIAS_2V4] |=> !r.sw_on)
        else $error("switcher on with bias under 2.4 V");
    AST_SWO_LDO: assert property (r.swover |-> !r.ldo_on)
        else $error("LDO left on after switch-over");
    AST_ILIM: assert property (!r.ldo_on |-> r.ilim == BFS_ILIM_65)
        else $error("LDO limit staged while off");

    COV_PG: cover property ($rose(r.pg));
    COV_SWO: cover property ($rose(r.swover));
    COV_UV: cover property ($rose(r.fault_uv));
    COV_FAST: cover property ($rose(r.fast_drop) ##[1:50] r.sw_on);

endmodule // bfs_seq

// >>> tb/bfs_board.sv
// Board-side model: comparator and enable pins, on-time pulses, pull-up.
// Assumes the sequencer clock; on-time pulses only while switching runs.
`timescale 1ns/100ps
module bfs_board
    import bfs_pkg::*;
#(
    parameter int PERIOD = 4
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic run_i,
    input wire bfs_flags_t pins_i,
    input wire logic pg_out_i,
    input wire logic pg_oe_i,
    output bfs_flags_t flags_o,
    output logic pg_pin_o
);
    logic [7:0] cnt;

    // ****************************************
    // Switching cycles
    // ****************************************
    always_ff @(posedge clock_i) begin
        if (!rst_n_i || !run_i) begin
            cnt <= 8'h00;
        end else begin
            cnt <= (cnt == 8'(PERIOD - 1)) ? 8'h00 : cnt + 8'h01;
        end
    end

    // One pulse per cycle, none when stopped
    assign flags_o = {run_i && cnt == 8'h01, pins_i[14:0]};
    // Pull-up: a released line reads high
    assign pg_pin_o = pg_oe_i ? pg_out_i : 1'b1;
endmodule // bfs_board

// >>> tb/bfs_seq_tb.sv
// Self-checking bench for the sequencer, one task per scenario.
// Assumes bfs_seq and the board model; single 125 MHz clock.
`timescale 1ns/100ps
`include "bfs_cfg.svh"
module bfs_seq_tb
    import bfs_pkg::*;
;
    localparam int SW = 0, LS = 1, TS = 2, LL = 3, PG = 4, LDO = 5;
    localparam int SWO = 6, PIN = 7;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    bfs_flags_t pins = 16'h0042;
    bfs_flags_t flags;
    wire [7:0] rdata;
    wire [1:0] ilim;
    wire sw_on, low_side, tristate, light_load_save, pg, pg_out, pg_oe;
    wire ldo_on, swo, poc, pg_pin;
    wire [7:0] obs = {pg_pin, swo, ldo_on, pg, light_load_save, tristate, low_side,
        sw_on};
    int mismatches = 0;
    int checks_done = 0;
    int cycles = 0;
    int poc_cnt = 0;

    bfs_seq bfs_seq_i (.clock_i(clock), .rst_n_i(rst_n), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_rdata_o(rdata), .cmp_flags_i(flags), .switcher_on_o(sw_on),
        .low_side_drive_o(low_side), .drive_tristate_o(tristate),
        .light_load_save_o(light_load_save), .power_good_flag_o(pg),
        .power_good_out_o(pg_out), .power_good_oe_o(pg_oe),
        .ldo_on_o(ldo_on), .switchover_close_o(swo),
        .soft_start_clear_o(poc), .ldo_ilim_o(ilim));
    bfs_board bfs_board_i (.clock_i(clock), .rst_n_i(rst_n), .run_i(sw_on),
        .pins_i(pins), .pg_out_i(pg_out), .pg_oe_i(pg_oe), .flags_o(flags),
        .pg_pin_o(pg_pin));

    always #4 clock = ~clock;

    // Ceiling well above the few thousand cycles the scenarios need
    always @(posedge clock) begin
        cycles++;
        if (poc === 1'b1) begin
            poc_cnt++;
        end
        if (cycles == 20000) begin
            mismatches++;
            summarize();
        end
    end

    // ****************************************
    // Helpers
    // ****************************************
    task automatic summarize();
        if (mismatches == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic bit_is(input int i, input logic v);
        chk({7'h0, obs[i]}, {7'h0, v});
    endtask

    task automatic wait_bit(input int i, input logic v, input int lim);
        int n;
        n = 0;
        while (obs[i] !== v && n < lim) begin
            cyc(1);
            n++;
        end
        chk({7'h0, obs[i]}, {7'h0, v});
    endtask

    task automatic set_pins(input bfs_flags_t mask, input bfs_flags_t val);
        @(posedge clock);
        pins <= (pins & ~mask) | (mask & val);
    endtask

    task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clock);
        wr <= 1'b0;
    endtask

    task automatic reg_rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clock);
        rd <= 1'b1;
        addr <= a;
        @(posedge clock);
        rd <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        cyc(1);
        bit_is(TS, 1'b1);
        bit_is(PIN, 1'b0);
        reg_rd(`BFS_REG_CTRL, `BFS_CTRL_RST);
        reg_rd(4'hc, 8'h00);
        reg_wr(`BFS_REG_CTRL, 8'h00);
        reg_rd(`BFS_REG_CTRL, 8'h00);
        reg_wr(`BFS_REG_CTRL, `BFS_CTRL_RST);
    endtask

    task automatic t_power();
        int p;
        set_pins(16'h0f00, 16'h0f00);
        wait_bit(LDO, 1'b1, 20);
        chk({6'h0, ilim}, 8'(BFS_ILIM_65));
        set_pins(16'h2000, 16'h2000);
        cyc(6);
        chk({6'h0, ilim}, 8'(BFS_ILIM_115));
        set_pins(16'h1000, 16'h1000);
        cyc(6);
        chk({6'h0, ilim}, 8'(BFS_ILIM_200));
        p = poc_cnt;
        set_pins(16'h0030, 16'h0030);
        cyc(8);
        chk(8'(poc_cnt - p), 8'h01);
        bit_is(PG, 1'b0);
        // Switcher enabled only once the LDO is at 90%
        set_pins(16'h00c0, 16'h0080);
        wait_bit(SW, 1'b1, 20);
        bit_is(TS, 1'b0);
        bit_is(LL, 1'b1);
        wait_bit(PIN, 1'b1, 20);
        reg_rd(`BFS_REG_STAT, 8'hb7);
        reg_rd(`BFS_REG_FAULT, 8'h00);
    endtask

    task automatic t_modes();
        set_pins(16'h00c0, 16'h0000);
        cyc(8);
        bit_is(SW, 1'b1);
        bit_is(LL, 1'b0);
        set_pins(16'h00c0, 16'h0040);
        wait_bit(SW, 1'b0, 10);
        bit_is(PG, 1'b0);
        set_pins(16'h00c0, 16'h0080);
        wait_bit(PG, 1'b1, 20);
    endtask

    task automatic t_hyst();
        set_pins(16'h0003, 16'h0001);
        wait_bit(PG, 1'b0, 8);
        set_pins(16'h0003, 16'h0000);
        cyc(10);
        bit_is(PG, 1'b0);
        set_pins(16'h0003, 16'h0002);
        wait_bit(PG, 1'b1, 8);
    endtask

    task automatic t_ovp();
        set_pins(16'h0004, 16'h0004);
        cyc(8);
        bit_is(PG, 1'b0);
        cyc(550);
        bit_is(LS, 1'b0);
        set_pins(16'h0004, 16'h0000);
        cyc(10);
        bit_is(LS, 1'b0);
        set_pins(16'h0004, 16'h0004);
        cyc(600);
        bit_is(LS, 1'b0);
        wait_bit(LS, 1'b1, 60);
        bit_is(SW, 1'b0);
        set_pins(16'h0004, 16'h0000);
        cyc(10);
        bit_is(LS, 1'b1);
        bit_is(PG, 1'b0);
        reg_rd(`BFS_REG_FAULT, 8'h01);
        set_pins(16'h00c0, 16'h0040);
        wait_bit(LS, 1'b0, 10);
        set_pins(16'h00c0, 16'h0080);
        wait_bit(SW, 1'b1, 10);
    endtask

    task automatic t_uv();
        int p;
        set_pins(16'h000b, 16'h0009);
        cyc(16);
        bit_is(SW, 1'b1);
        wait_bit(SW, 1'b0, 40);
        bit_is(TS, 1'b1);
        reg_rd(`BFS_REG_FAULT, 8'h02);
        set_pins(16'h000b, 16'h0002);
        cyc(10);
        bit_is(SW, 1'b0);
        set_pins(16'h0030, 16'h0000);
        cyc(6);
        bit_is(TS, 1'b1);
        p = poc_cnt;
        set_pins(16'h0030, 16'h0030);
        wait_bit(SW, 1'b1, 20);
        chk(8'(poc_cnt - p), 8'h01);
        reg_rd(`BFS_REG_FAULT, 8'h00);
    endtask

    task automatic t_enl();
        set_pins(16'h0f00, 16'h0c00);
        wait_bit(SW, 1'b0, 30);
        bit_is(LDO, 1'b1);
        set_pins(16'h0f00, 16'h0e00);
        cyc(12);
        bit_is(SW, 1'b0);
        set_pins(16'h0f00, 16'h0f00);
        wait_bit(SW, 1'b1, 20);
        set_pins(16'h0f00, 16'h0000);
        wait_bit(LDO, 1'b0, 30);
        cyc(10);
        bit_is(SW, 1'b1);
        set_pins(16'h0f00, 16'h0f00);
        wait_bit(LDO, 1'b1, 20);
    endtask

    task automatic t_swo();
        // Rails near each other only here, apart everywhere else
        set_pins(16'h40c0, 16'h4040);
        wait_bit(SW, 1'b0, 10);
        set_pins(16'h00c0, 16'h0080);
        wait_bit(PG, 1'b1, 30);
        cyc(100);
        bit_is(SWO, 1'b0);
        wait_bit(SWO, 1'b1, 60);
        bit_is(LDO, 1'b0);
    endtask

    initial begin
        repeat (12) @(posedge clock);
        rst_n <= 1'b1;
        t_reset();
        t_power();
        t_modes();
        t_hyst();
        t_ovp();
        t_uv();
        t_enl();
        t_swo();
        summarize();
    end
endmodule // bfs_seq_tb
